// ===== serial_if.v
// Serial interface: registers, status flags, interrupt mask, per-select timing and master shifter.
//
// Implementation choices: the strobed register port and the address map.
`include "serial_if_defines.vh"
module serial_if
(
   // Clock and reset
   input wire REF_CLK_I,
   input wire RST_N_I,
   // Register port
   input wire [7:0] ADDR_I,
   input wire [31:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   output wire [31:0] RDATA_O,
   // Serial pins
   input wire MISO_I,
   input wire SLAVE_SELECT_IN_I,
   output wire SERIAL_CLOCK_OUT_O,
   output wire MOSI_O,
   output wire [3:0] PERIPHERAL_SELECT_LINES_O,
   // Fault and DMA counter status
   input wire MODE_FAULT_I,
   input wire RX_CNT_ZERO_I,
   input wire RX_NEXT_ZERO_I,
   input wire TX_CNT_ZERO_I,
   input wire TX_NEXT_ZERO_I,
   input wire RX_CNT_WR_I,
   input wire TX_CNT_WR_I,
   // Interrupt
   output wire IRQ_O
);
   localparam S_IDLE = 3'd0;
   localparam S_LEAD = 3'd2;
   localparam S_TRAIL = 3'd3;
   localparam S_GAP = 3'd4;

   reg [31:0] csr_ff [0:3];
   reg [31:0] mode_ff;
   reg [31:0] rdata_ff;
   reg enable_ff;
   reg [15:0] hold_ff;
   reg [1:0] hold_cs_ff;
   reg hold_last_ff;
   reg tx_holding_empty_ff;
   reg rx_holding_full_ff;
   reg mode_fault_flag_ff;
   reg overrun_flag_ff;
   reg rx_dma_count_done_ff;
   reg tx_dma_count_done_ff;
   reg select_rise_flag_ff;
   reg transmit_complete_ff;
   reg [9:0] imask_ff;
   reg irq_ff;
   reg [15:0] rx_data_ff;
   reg rx_zero_q_ff;
   reg tx_zero_q_ff;
   reg ss_q_ff;
   reg [2:0] state_ff;
   reg [12:0] tmr_ff;
   reg [4:0] bit_ff;
   reg [15:0] tx_sh_ff;
   reg [15:0] rx_sh_ff;
   reg [1:0] cur_cs_ff;
   reg cur_last_ff;
   reg sel_act_ff;
   reg sck_ff;
   reg mosi_ff;
   reg [3:0] sel_n_ff;

   wire [3:0] csr_wr;
   wire st_rd = RD_I && (ADDR_I == `A_STATUS);
   wire rx_rd = RD_I && (ADDR_I == `A_RXDATA);
   wire tx_wr = WR_I && (ADDR_I == `A_TXDATA) && enable_ff;
   wire ctrl_wr = WR_I && (ADDR_I == `A_CTRL);
   wire en_cmd = ctrl_wr && WDATA_I[`CTRL_EN] && !WDATA_I[`CTRL_DIS];
   wire dis_cmd = ctrl_wr && WDATA_I[`CTRL_DIS];
   wire rx_dma_all_done = RX_CNT_ZERO_I && RX_NEXT_ZERO_I;
   wire tx_dma_all_done = TX_CNT_ZERO_I && TX_NEXT_ZERO_I;

   // Active configuration follows the select of the word in flight.
   wire [31:0] cfg = csr_ff[cur_cs_ff];
   wire clock_idle_level = cfg[0];
   wire clock_sample_phase = cfg[1];
   wire hold_select_after = cfg[3];
   wire [4:0] nbits = {1'b0, cfg[7:4]} + `WORD_BASE;
   wire [7:0] baud_divider = cfg[15:8];
   wire [7:0] select_to_clock_delay = cfg[23:16];
   wire [7:0] inter_word_delay = cfg[31:24];

   // An odd divider gives the extra cycle to the first half of the period.
   wire [7:0] half2_raw = {1'b0, baud_divider[7:1]};
   wire [12:0] half1 = {5'h00, baud_divider - half2_raw};
   wire [12:0] half2 = (half2_raw == 8'h00) ? 13'h0001 : {5'h00, half2_raw};
   wire [12:0] gap_len = {inter_word_delay, 5'h00};

   wire [1:0] new_cs = mode_ff[`MODE_VARSEL] ? hold_cs_ff : mode_ff[`MODE_FIXCS_LO+1:`MODE_FIXCS_LO];
   wire [31:0] new_cfg = csr_ff[new_cs];
   wire [4:0] new_bits = {1'b0, new_cfg[7:4]} + `WORD_BASE;
   // Setup is counted from the edge that drives the select low, so it uses the incoming select's fields.
   wire [12:0] new_half1 = {5'h00, new_cfg[15:8] - {1'b0, new_cfg[15:9]}};
   wire [12:0] new_setup = (new_cfg[23:16] == 8'h00) ? new_half1 : {5'h00, new_cfg[23:16]};
   wire [4:0] new_shift = `WORD_MAX - new_bits;
   wire [15:0] new_aligned = hold_ff << new_shift;
   wire go = enable_ff && mode_ff[`MODE_MASTER] && !tx_holding_empty_ff;
   wire same_sel = sel_act_ff && (cur_cs_ff == new_cs);
   wire load_now = (state_ff == S_IDLE) && go && (!sel_act_ff || same_sel);
   wire tmr_done = (tmr_ff == 13'h0000);
   wire last_bit = (bit_ff == nbits - 5'h01);
   wire word_done = (state_ff == S_TRAIL) && tmr_done && last_bit;
   wire [16:0] word_mask = (17'h00001 << nbits) - 17'h00001;
   wire [15:0] rx_raw = clock_sample_phase ? rx_sh_ff : {rx_sh_ff[14:0], MISO_I};
   wire [15:0] rx_word = rx_raw & word_mask[15:0];
   wire gap_end = (state_ff == S_GAP) && tmr_done;
   wire keep_sel = (hold_select_after && !cur_last_ff) ||
                   (go && !cur_last_ff && cur_cs_ff == new_cs);

   wire [9:0] flags = {transmit_complete_ff, select_rise_flag_ff, tx_dma_all_done, rx_dma_all_done,
                       tx_dma_count_done_ff, rx_dma_count_done_ff, overrun_flag_ff, mode_fault_flag_ff,
                       tx_holding_empty_ff, rx_holding_full_ff};

   // Per-select configuration registers.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_csr
         assign csr_wr[gi] = WR_I && (ADDR_I[7:2] == `A_CSR_BASE + gi);
         always @(posedge REF_CLK_I)
         begin
            if (!RST_N_I)
               csr_ff[gi] <= `CSR_RESET;
            else if (csr_wr[gi])
               csr_ff[gi] <= WDATA_I & `CSR_MASK;
         end
      end
   endgenerate

   // Register writes, enable, mask and read data.
   always @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         mode_ff <= 32'h00000000;
         enable_ff <= 1'b0;
         imask_ff <= 10'h000;
         hold_ff <= 16'h0000;
         hold_cs_ff <= 2'h0;
         hold_last_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
         irq_ff <= 1'b0;
      end
      else
      begin
         if (dis_cmd)
            enable_ff <= 1'b0;
         else if (en_cmd)
            enable_ff <= 1'b1;
         if (WR_I && ADDR_I == `A_MODE)
            mode_ff <= WDATA_I & `MODE_MASK;
         if (WR_I && ADDR_I == `A_IEN)
            imask_ff <= imask_ff | WDATA_I[9:0];
         if (WR_I && ADDR_I == `A_IDIS)
            imask_ff <= imask_ff & ~WDATA_I[9:0];
         if (tx_wr)
         begin
            hold_ff <= WDATA_I[15:0];
            hold_cs_ff <= WDATA_I[`TX_CS_LO+1:`TX_CS_LO];
            hold_last_ff <= WDATA_I[`TX_LAST];
         end
         irq_ff <= |(flags & imask_ff);
         rdata_ff <= 32'h00000000;
         if (RD_I)
         begin
            case (ADDR_I)
               `A_MODE: rdata_ff <= mode_ff;
               `A_RXDATA: rdata_ff <= {16'h0000, rx_data_ff};
               `A_STATUS: rdata_ff <= {15'h0000, enable_ff, 6'h00, flags};
               `A_IMASK: rdata_ff <= {22'h000000, imask_ff};
               default:
               begin
                  if (ADDR_I[7:4] == `A_CSR0 >> 4)
                     rdata_ff <= csr_ff[ADDR_I[3:2]];
                  else
                     rdata_ff <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // Status flags; an event in the cycle of its clear wins over the clear, except transmit-empty and transmit-complete, where a data write wins.
   always @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         tx_holding_empty_ff <= 1'b0;
         rx_holding_full_ff <= 1'b0;
         mode_fault_flag_ff <= 1'b0;
         overrun_flag_ff <= 1'b0;
         rx_dma_count_done_ff <= 1'b0;
         tx_dma_count_done_ff <= 1'b0;
         select_rise_flag_ff <= 1'b0;
         transmit_complete_ff <= 1'b0;
         rx_data_ff <= 16'h0000;
         rx_zero_q_ff <= 1'b0;
         tx_zero_q_ff <= 1'b0;
         ss_q_ff <= 1'b1;
      end
      else
      begin
         rx_zero_q_ff <= RX_CNT_ZERO_I;
         tx_zero_q_ff <= TX_CNT_ZERO_I;
         ss_q_ff <= SLAVE_SELECT_IN_I;
         if (dis_cmd)
            tx_holding_empty_ff <= 1'b0;
         else if (en_cmd)
            tx_holding_empty_ff <= 1'b1;
         else if (tx_wr)
            tx_holding_empty_ff <= 1'b0;
         else if (load_now)
            tx_holding_empty_ff <= 1'b1;
         if (word_done)
         begin
            rx_data_ff <= rx_word;
            rx_holding_full_ff <= 1'b1;
         end
         else if (rx_rd)
            rx_holding_full_ff <= 1'b0;
         if (word_done && rx_holding_full_ff && !rx_rd)
            overrun_flag_ff <= 1'b1;
         else if (st_rd)
            overrun_flag_ff <= 1'b0;
         if (MODE_FAULT_I)
            mode_fault_flag_ff <= 1'b1;
         else if (st_rd)
            mode_fault_flag_ff <= 1'b0;
         if (SLAVE_SELECT_IN_I && !ss_q_ff)
            select_rise_flag_ff <= 1'b1;
         else if (st_rd)
            select_rise_flag_ff <= 1'b0;
         if (RX_CNT_ZERO_I && !rx_zero_q_ff)
            rx_dma_count_done_ff <= 1'b1;
         else if (RX_CNT_WR_I)
            rx_dma_count_done_ff <= 1'b0;
         if (TX_CNT_ZERO_I && !tx_zero_q_ff)
            tx_dma_count_done_ff <= 1'b1;
         else if (TX_CNT_WR_I)
            tx_dma_count_done_ff <= 1'b0;
         if (tx_wr)
            transmit_complete_ff <= 1'b0;
         else if (gap_end && tx_holding_empty_ff)
            transmit_complete_ff <= 1'b1;
      end
   end

   // Master shifter: select setup, clock halves, inter-word gap.
   always @(posedge REF_CLK_I)
   begin
      if (!RST_N_I)
      begin
         state_ff <= S_IDLE;
         tmr_ff <= 13'h0000;
         bit_ff <= 5'h00;
         tx_sh_ff <= 16'h0000;
         rx_sh_ff <= 16'h0000;
         cur_cs_ff <= 2'h0;
         cur_last_ff <= 1'b0;
         sel_act_ff <= 1'b0;
         sel_n_ff <= 4'hf;
         sck_ff <= 1'b0;
         mosi_ff <= 1'b0;
      end
      else
      begin
         if (!tmr_done)
            tmr_ff <= tmr_ff - 13'h0001;
         case (state_ff)
            S_IDLE:
            begin
               if (!sel_act_ff)
                  sck_ff <= csr_ff[new_cs][0];
               if (go && sel_act_ff && !same_sel)
               begin
                  sel_act_ff <= 1'b0;
                  sel_n_ff <= 4'hf;
               end
               else if (load_now)
               begin
                  cur_cs_ff <= new_cs;
                  cur_last_ff <= hold_last_ff;
                  tx_sh_ff <= new_aligned;
                  bit_ff <= 5'h00;
                  if (new_cfg[1])
                     mosi_ff <= new_aligned[15];
                  sel_act_ff <= 1'b1;
                  sel_n_ff <= ~(4'h1 << new_cs);
                  if (same_sel)
                  begin
                     state_ff <= S_LEAD;
                     tmr_ff <= new_half1 - 13'h0001;
                  end
                  else
                  begin
                     state_ff <= S_LEAD;
                     tmr_ff <= new_setup - 13'h0001;
                  end
               end
            end
            S_LEAD:
            begin
               if (tmr_done)
               begin
                  sck_ff <= ~clock_idle_level;
                  if (clock_sample_phase)
                     rx_sh_ff <= {rx_sh_ff[14:0], MISO_I};
                  else
                  begin
                     mosi_ff <= tx_sh_ff[15];
                     tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
                  end
                  tmr_ff <= half2 - 13'h0001;
                  state_ff <= S_TRAIL;
               end
            end
            S_TRAIL:
            begin
               if (tmr_done)
               begin
                  sck_ff <= clock_idle_level;
                  if (clock_sample_phase)
                  begin
                     mosi_ff <= tx_sh_ff[14];
                     tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
                  end
                  else
                     rx_sh_ff <= {rx_sh_ff[14:0], MISO_I};
                  if (last_bit)
                  begin
                     state_ff <= S_GAP;
                     // The gap state always costs one cycle, so the full count is added on top of it.
                     tmr_ff <= gap_len;
                  end
                  else
                  begin
                     bit_ff <= bit_ff + 5'h01;
                     tmr_ff <= half1 - 13'h0001;
                     state_ff <= S_LEAD;
                  end
               end
            end
            S_GAP:
            begin
               if (tmr_done)
               begin
                  state_ff <= S_IDLE;
                  if (!keep_sel)
                  begin
                     sel_act_ff <= 1'b0;
                     sel_n_ff <= 4'hf;
                  end
               end
            end
            default:
            begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   assign RDATA_O = rdata_ff;
   assign SERIAL_CLOCK_OUT_O = sck_ff;
   assign MOSI_O = mosi_ff;
   assign PERIPHERAL_SELECT_LINES_O = sel_n_ff;
   assign IRQ_O = irq_ff;
endmodule

// ===== serial_if_chk.sv
// Checker for status, mask, enable and interrupt behaviour seen at the serial interface ports.
`include "serial_if_defines.vh"
module serial_if_chk
(
   // Clock, reset and register port
   input wire REF_CLK_I,
   input wire RST_N_I,
   input wire [7:0] ADDR_I,
   input wire [31:0] WDATA_I,
   input wire WR_I,
   input wire RD_I,
   input wire [31:0] RDATA_O,
   // Events, counters and outputs
   input wire MODE_FAULT_I,
   input wire RX_CNT_ZERO_I,
   input wire RX_NEXT_ZERO_I,
   input wire TX_CNT_ZERO_I,
   input wire TX_NEXT_ZERO_I,
   input wire [3:0] PERIPHERAL_SELECT_LINES_O,
   input wire IRQ_O
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en_ff;
   logic fault_ff;
   logic [9:0] mask_ff;
   wire rd_st = RD_I && ADDR_I == `A_STATUS;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RST_N_I);
   // Shadow state; a fault in the cycle of a status read survives, since set wins over clear.
   always @(posedge REF_CLK_I)
      if (!RST_N_I)
      begin
         en_ff <= 1'b0;
         fault_ff <= 1'b0;
         mask_ff <= 10'h0;
      end
      else
      begin
         if (WR_I && ADDR_I == `A_CTRL)
            en_ff <= !WDATA_I[1] && (WDATA_I[0] || en_ff);
         if (WR_I && ADDR_I == `A_IEN)
            mask_ff <= mask_ff | WDATA_I[9:0];
         if (WR_I && ADDR_I == `A_IDIS)
            mask_ff <= mask_ff & ~WDATA_I[9:0];
         fault_ff <= MODE_FAULT_I || (fault_ff && !rd_st);
      end
   chk_mask_read: assert property (RD_I && ADDR_I == `A_IMASK |=> RDATA_O == {22'h0, $past(mask_ff)})
      else $error("mask readback wrong");
   chk_enable_state: assert property (rd_st |=> RDATA_O[16] == $past(en_ff))
      else $error("enable state wrong");
   chk_hold_disabled: assert property (rd_st && !en_ff |=> !RDATA_O[1])
      else $error("holding empty set while disabled");
   chk_fault_sticky: assert property (rd_st |=> RDATA_O[2] == $past(fault_ff))
      else $error("mode fault flag wrong");
   chk_rx_all: assert property (rd_st && $stable(RX_CNT_ZERO_I & RX_NEXT_ZERO_I)
      |=> RDATA_O[6] == $past(RX_CNT_ZERO_I & RX_NEXT_ZERO_I, 2))
      else $error("rx all done wrong");
   chk_tx_all: assert property (rd_st && $stable(TX_CNT_ZERO_I & TX_NEXT_ZERO_I)
      |=> RDATA_O[7] == $past(TX_CNT_ZERO_I & TX_NEXT_ZERO_I, 2))
      else $error("tx all done wrong");
   chk_irq_masked: assert property (mask_ff == 10'h0 && $past(mask_ff) == 10'h0 |-> !IRQ_O)
      else $error("irq without mask");
   chk_irq_fault: assert property (fault_ff && mask_ff[2] && $past(fault_ff && mask_ff[2]) |-> IRQ_O)
      else $error("irq missing on fault");
   cov_fault: cover property (rd_st ##1 RDATA_O[2]);
   cov_irq: cover property (IRQ_O);
   cov_select: cover property (PERIPHERAL_SELECT_LINES_O != 4'hf);
endmodule
bind serial_if serial_if_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .MODE_FAULT_I(MODE_FAULT_I),
   .RX_CNT_ZERO_I(RX_CNT_ZERO_I), .RX_NEXT_ZERO_I(RX_NEXT_ZERO_I), .TX_CNT_ZERO_I(TX_CNT_ZERO_I),
   .TX_NEXT_ZERO_I(TX_NEXT_ZERO_I), .PERIPHERAL_SELECT_LINES_O(PERIPHERAL_SELECT_LINES_O), .IRQ_O(IRQ_O));

// ===== serial_if_defines.vh
// Register offsets, field positions, reset values and timing constants of the serial interface block.
// What this block does
// - Transmit-empty sets when held word moves to shifter, clears while new word waits.
// - Transmit-empty reads zero at reset or disabled; the enable command forces it to one.
// - Mode-fault flag latches on a fault and clears when status is read.
// - Overrun latches on a second receive load without a receive read; status read clears.
// - Receive DMA end flag sets when its counter reaches 0; counter writes clear it.
// - Transmit DMA end flag sets when its counter reaches 0; counter writes clear it.
// - Receive DMA all-done reads one only while both receive counters are 0.
// - Transmit DMA all-done reads one only while both transmit counters are 0.
// - Select-rise flag latches on each slave-select rising edge; status read clears it.
// - Transmit-complete clears on a data write, sets when all empty and gap elapsed.
// - Enable-state bit reads one while enabled, zero while disabled.
// - Writing one to an enable bit sets the mask bit; zero leaves it.
// - Writing one to a disable bit clears the mask bit; zero leaves it.
// - Mask register reads the ten enabled sources at the status bit positions.
// - Per select, the idle-level bit sets the serial clock idle level.
// - Phase zero changes data on leading edge; phase one samples on leading edge.
// - With hold off, the select line is released once the last transfer's inter-word delay has elapsed.
// - With hold on, the select stays active until another select is requested or a word marked last ends.
// - Word-length codes 0000 to 1000 give 8 to 16 bits; higher codes reserved.
// - Master serial clock is the master clock divided by the 8-bit divider, 2 to 255; a divider of 1 also divides by 2.
// - Select-to-clock delay is half a clock period at zero, else field master clocks.
// - Consecutive transfers get 32 master clocks per inter-word delay unit, none at zero.
// - Receive-full sets when a word reaches receive data; reading receive data clears it.
`ifndef SERIAL_IF_DEFINES_VH
`define SERIAL_IF_DEFINES_VH
`define A_CTRL 8'h00
`define A_MODE 8'h04
`define A_RXDATA 8'h08
`define A_TXDATA 8'h0c
`define A_STATUS 8'h10
`define A_IEN 8'h14
`define A_IDIS 8'h18
`define A_IMASK 8'h1c
`define A_CSR0 8'h30
`define A_CSR_BASE 6'hc
`define CTRL_EN 0
`define CTRL_DIS 1
`define MODE_MASTER 0
`define MODE_VARSEL 1
`define MODE_FIXCS_LO 16
`define TX_CS_LO 16
`define TX_LAST 24
`define ST_RXFULL 0
`define ST_TRANSMIT_COMPLETE 1
`define ST_MODE_FAULT_FLAG 2
`define ST_OVR 3
`define ST_RX_DMA_COUNT_DONE 4
`define ST_TX_DMA_COUNT_DONE 5
`define ST_RX_DMA_ALL_DONE 6
`define ST_TX_DMA_ALL_DONE 7
`define ST_SELRISE 8
`define ST_TXCOMP 9
`define ST_ENS 16
`define NUM_FLAGS 10
`define CSR_MASK 32'hfffffffb
`define CSR_RESET 32'h00000000
`define MODE_MASK 32'h00030003
`define WORD_BASE 5'h08
`define WORD_MAX 5'h10
`define GAP_UNIT_SHIFT 5
`endif

// ===== serial_periph.sv
// Behavioural serial peripheral that records the master's word and answers with a given one.
module serial_periph
(
   // Clock and pins
   input wire logic clk_i,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic [3:0] sel_n_i,
   output logic miso_o,
   // Setup and results
   input wire logic [1:0] cfg_i,
   input wire logic [15:0] tx_i,
   output logic [15:0] rx_o,
   output int nbits_o,
   output int setup_o,
   output int per_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck_q;
   logic [3:0] sel_q;
   int cyc;
   int t0;
   int ts;
   bit first;
   initial miso_o = 1'b0;
   // Pins are sampled on the master clock, so every event is seen one cycle late and spans stay exact.
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      sck_q <= sck_i;
      sel_q <= sel_n_i;
      if (sel_n_i == 4'hf)
         miso_o <= ~miso_o;
      else if (sel_n_i != sel_q)
      begin
         nbits_o <= 0;
         t0 <= cyc;
         first <= 1'b1;
         miso_o <= tx_i[15];
      end
      else if (sck_i != sck_q)
      begin
         first <= 1'b0;
         if (first)
            setup_o <= cyc - t0;
         if ((sck_q == cfg_i[0]) == cfg_i[1])
         begin
            rx_o <= {rx_o[14:0], mosi_i};
            nbits_o <= nbits_o + 1;
            per_o <= cyc - ts;
            ts <= cyc;
         end
         else
            miso_o <= tx_i[(15 - nbits_o) & 15];
      end
   end
endmodule

// ===== test_serial_if.sv
// Register-level testbench of the serial interface with a peripheral model on its pins.
`include "serial_if_defines.vh"
module test_serial_if;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, rst_n, wr_s, rd_s, fault, ss_in, miso, sck, mosi, irq;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, d;
   logic [3:0] zr, sel_n, lo_sel;
   logic [1:0] cw, pcfg;
   logic [15:0] ptx, pl, prx;
   int pbits, psetup, pper, n_errors, check_count, lo_cnt, lo_len, lo0, len, ov;
   logic [31:0] csr [7] = '{32'h00000800, 32'h01000800, 32'h00050681, 32'h00000432, 32'h00030a0b, 32'h00000800,
      32'h00000808};
   serial_if u_dut (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
      .RD_I(rd_s), .RDATA_O(rdata), .MISO_I(miso), .SLAVE_SELECT_IN_I(ss_in), .SERIAL_CLOCK_OUT_O(sck),
      .MOSI_O(mosi), .PERIPHERAL_SELECT_LINES_O(sel_n), .MODE_FAULT_I(fault), .RX_CNT_ZERO_I(zr[0]),
      .RX_NEXT_ZERO_I(zr[1]), .TX_CNT_ZERO_I(zr[2]), .TX_NEXT_ZERO_I(zr[3]), .RX_CNT_WR_I(cw[0]),
      .TX_CNT_WR_I(cw[1]), .IRQ_O(irq));
   serial_periph u_per (.clk_i(ref_clk), .sck_i(sck), .mosi_i(mosi), .sel_n_i(sel_n), .miso_o(miso),
      .cfg_i(pcfg), .tx_i(pl), .rx_o(prx), .nbits_o(pbits), .setup_o(psetup), .per_o(pper));
   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
      if (sel_n !== 4'hf)
      begin
         lo_cnt <= lo_cnt + 1;
         lo_sel <= sel_n;
      end
      else if (lo_cnt != 0)
      begin
         lo_len <= lo_cnt;
         lo_cnt <= 0;
      end
   task automatic results;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %0t %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      wr_s <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a);
      @(posedge ref_clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_s <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
      reg_rd(a);
      check(d & m, e, s);
   endtask
   task automatic xfer(input int i);
      logic [31:0] c;
      logic [15:0] w, mk;
      c = csr[i];
      len = c[7:4] + 8;
      mk = 16'((32'h1 << len) - 1);
      w = 16'h9e37 >> i;
      ptx = 16'hc35a >> i;
      pl = ptx << (16 - len);
      pcfg = c[1:0];
      if (i >= 5)
         reg_wr(`A_MODE, i == 5 ? 32'h00010001 : 32'h00000003);
      reg_wr(i == 5 ? 8'h34 : i == 6 ? 8'h38 : `A_CSR0, c);
      repeat (2) @(posedge ref_clk);
      #1 if (i < 5) check(32'(sck), 32'(c[0]), "idle level");
      reg_wr(`A_TXDATA, {7'h00, i == 6, 6'h00, i == 6 ? 2'h2 : 2'h0, w});
      ov = 0;
      for (int n = 0; n < 300; n++)
      begin
         reg_rd(`A_STATUS);
         ov |= d[3];
         if (n == 0)
            check(32'(d[9]), 0, "complete cleared");
         if (d[9] && n > 0)
            break;
      end
      check(d & 32'h203, 32'h203, "complete, rx full, tx empty");
      repeat (2) @(posedge ref_clk);
      check(32'(prx & mk), 32'(w & mk), "mosi word");
      check(pbits, len, "bit count");
      check(pper, 32'(c[15:8]), "period");
      check(psetup, c[23:16] != 0 ? 32'(c[23:16]) : 32'(c[15:8]) / 2, "setup");
      check(32'(sel_n), i == 4 ? 32'he : 32'hf, "select after");
      check(32'(lo_sel), i == 6 ? 32'hb : i == 5 ? 32'hd : 32'he, "select line");
      check(ov, 32'(i == 4), "overrun");
      if (i == 0)
         lo0 = lo_len;
      if (i == 1)
         check(lo_len - lo0, 32, "gap");
      if (i != 3)
      begin
         chk(`A_RXDATA, 32'hffff, 32'(ptx & mk), "miso word");
         chk(`A_STATUS, 32'h1, 32'h0, "rx full clear");
      end
   endtask
   initial
   begin
      rst_n = 0; wr_s = 0; rd_s = 0; addr = 0; wdata = 0; fault = 0; ss_in = 0;
      zr = 0; cw = 0; pcfg = 0; ptx = 0; pl = 0;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      chk(`A_STATUS, 32'h100ff, 32'h0, "reset status");
      chk(`A_CSR0, 32'hffffffff, 32'h0, "select config reset");
      reg_wr(8'h44, 32'hffffffff);
      chk(8'h40, 32'hffffffff, 32'h0, "unmapped");
      reg_wr(`A_IEN, 32'h155);
      reg_wr(`A_IEN, 32'h0);
      chk(`A_IMASK, 32'hffffffff, 32'h155, "mask set");
      reg_wr(`A_IDIS, 32'h5);
      reg_wr(`A_IDIS, 32'h0);
      chk(`A_IMASK, 32'hffffffff, 32'h150, "mask clear");
      reg_wr(`A_IDIS, 32'h3ff);
      reg_wr(`A_CTRL, 32'h1);
      chk(`A_STATUS, 32'h10002, 32'h10002, "enabled");
      reg_wr(`A_IEN, 32'h4);
      @(posedge ref_clk) fault <= 1'b1;
      @(posedge ref_clk) fault <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 check(32'(irq), 1, "irq on fault");
      chk(`A_STATUS, 32'h4, 32'h4, "fault set");
      chk(`A_STATUS, 32'h4, 32'h0, "fault clear");
      check(32'(irq), 0, "irq low");
      @(posedge ref_clk) ss_in <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk(`A_STATUS, 32'h100, 32'h100, "select rise");
      chk(`A_STATUS, 32'h100, 32'h0, "select rise clear");
      for (int k = 0; k < 2; k++)
      begin
         @(posedge ref_clk) zr[2 * k] <= 1'b1;
         chk(`A_STATUS, 32'h50 << k, 32'h10 << k, "count done");
         @(posedge ref_clk) zr[2 * k + 1] <= 1'b1;
         @(posedge ref_clk) cw[k] <= 1'b1;
         @(posedge ref_clk) cw[k] <= 1'b0;
         chk(`A_STATUS, 32'h50 << k, 32'h40 << k, "all done");
      end
      @(posedge ref_clk) zr <= 4'h0;
      reg_wr(`A_MODE, 32'h1);
      for (int i = 0; i < 7; i++)
         xfer(i);
      reg_wr(`A_CTRL, 32'h2);
      chk(`A_STATUS, 32'h10002, 32'h0, "disabled");
      results;
   end
   initial
   begin
      repeat (40000) @(posedge ref_clk);
      n_errors++;
      results;
   end
endmodule
